// ===== design/efo_pkg.sv
package efo_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned MS_TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned FORCE_TIMEOUT_MIN = 5;
    localparam int unsigned FORCE_TIMEOUT_MS = FORCE_TIMEOUT_MIN * 60 * 1000;
    localparam logic [15:0] PEAK_LEN_MS = 16'h0001;
    localparam logic [15:0] PEAK_STEP_MS = 16'h0014;
    // Per-unit values are unsigned 8.8 fixed point
    localparam logic [15:0] NOMINAL_PU = 16'h0100;
    localparam logic [15:0] RES_LIMIT = 16'h0a00;
    localparam logic [15:0] PHASE_LIMIT = 16'h3200;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_IRQ_STATUS = 8'h04;
    localparam logic [7:0] REG_IRQ_MASK = 8'h08;
    localparam logic [7:0] REG_STATE = 8'h0c;
    localparam logic [7:0] REG_CNT_CLEAR = 8'h10;
    // Stage blocks at 0x80 + stage * 0x20, word index within the block
    localparam logic [2:0] SREG_PICKUP_G0 = 3'h0;
    localparam logic [2:0] SREG_PICKUP_G1 = 3'h1;
    localparam logic [2:0] SREG_DELAY_G0 = 3'h2;
    localparam logic [2:0] SREG_DELAY_G1 = 3'h3;
    localparam logic [2:0] SREG_CFG = 3'h4;
    localparam logic [2:0] SREG_COUNTS = 3'h5;
    localparam logic [2:0] SREG_PRIMARY = 3'h6;
    localparam logic [2:0] SREG_CT_RATING = 3'h7;
    localparam int unsigned CTRL_FORCE_BIT = 0;
    localparam int unsigned CTRL_GROUP_BIT = 1;
    localparam int unsigned CTRL_SRC_LSB = 2;
    localparam int unsigned CTRL_FSTART_LSB = 8;
    localparam int unsigned CTRL_FTRIP_LSB = 12;
    localparam logic [15:0] PICKUP_RESET = 16'h0100;
    localparam logic [15:0] DELAY_RESET = 16'h0064;
    localparam logic [15:0] CT_RESET = 16'h0001;
    typedef enum logic [2:0] {SRC_A, SRC_B, SRC_CALC, SRC_A_PEAK, SRC_B_PEAK} efo_input_e;
    typedef enum logic [2:0] {GSRC_NONE, GSRC_DI, GSRC_VI, GSRC_LED, GSRC_VO} efo_gsrc_e;
endpackage

// ===== design/efo_stage_top.sv
`timescale 1ns/1ps
module efo_stage_top #(
    parameter int unsigned NUM_STAGES = 4,
    parameter int unsigned MS_TICK_CYCLES = efo_pkg::MS_TICK_CYCLES,
    parameter int unsigned FORCE_TIMEOUT_MS = efo_pkg::FORCE_TIMEOUT_MS
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    input wire logic [15:0] residual_input_a_i,
    input wire logic [15:0] residual_input_b_i,
    input wire logic [15:0] summed_phase_residual_i,
    input wire logic [15:0] peak_input_a_i,
    input wire logic [15:0] peak_input_b_i,
    input wire logic group_di_i,
    input wire logic group_vi_i,
    input wire logic group_led_i,
    input wire logic group_vo_i,
    output logic [NUM_STAGES-1:0] start_o,
    output logic [NUM_STAGES-1:0] trip_o,
    output logic active_group_o,
    output logic force_o,
    output logic irq_o
);
    logic [15:0] pickup [NUM_STAGES][2];
    logic [15:0] delay [NUM_STAGES][2];
    logic [2:0] input_sel [NUM_STAGES];
    logic inverse_en [NUM_STAGES];
    logic [15:0] intermit [NUM_STAGES];
    logic [15:0] ct_rating [NUM_STAGES];
    logic [15:0] acc [NUM_STAGES], idle [NUM_STAGES];
    logic [15:0] start_event_count [NUM_STAGES], trip_event_count [NUM_STAGES];
    logic [NUM_STAGES-1:0] peak_hold, over, start_q, trip_q, start_d, trip_d;
    logic [15:0] meas [NUM_STAGES], step [NUM_STAGES];
    logic [31:0] ctrl;
    logic [7:0] irq_status;
    logic [7:0] irq_mask;
    logic [NUM_STAGES-1:0] cnt_clear;
    logic [31:0] tick_cnt;
    logic ms_tick;
    logic [31:0] force_cnt;
    logic active_group;
    logic force_flag;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic wr_en;
    logic [7:0] events;

    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lim);
        clamp = (v > lim) ? lim : v;
    endfunction

    // Step doubles with each doubling of the pick-up multiple up to 16, so the delay shrinks
    function automatic logic [15:0] inv_step(input logic [15:0] m, input logic [15:0] pu);
        inv_step = 16'h0001;
        for (int k = 1; k <= 4; k++)
        begin
            if ({4'h0, m} >= ({4'h0, pu} << k))
                inv_step = 16'h0001 << k;
        end
    endfunction
    function automatic logic [15:0] sat_add(input logic [15:0] a, input logic [15:0] b);
        logic [16:0] s;
        s = {1'b0, a} + {1'b0, b};
        sat_add = s[16] ? 16'hffff : s[15:0];
    endfunction

    assign hreadyout_o = 1'b1;
    assign hresp_o = 1'b0;
    assign start_o = start_q;
    assign trip_o = trip_q;
    assign active_group_o = active_group;
    assign force_o = force_flag;
    assign irq_o = |(irq_status & irq_mask);
    assign wr_en = wr_pend;

    always_ff @(posedge clk_i)
    begin
        tick_cnt <= (rst_i || ms_tick) ? 32'h0 : tick_cnt + 32'h1;
    end
    assign ms_tick = (tick_cnt == MS_TICK_CYCLES - 1);

    // Group source picks the active set
    always_comb
    begin
        case (efo_pkg::efo_gsrc_e'(ctrl[efo_pkg::CTRL_SRC_LSB +: 3]))
            efo_pkg::GSRC_DI: active_group = group_di_i;
            efo_pkg::GSRC_VI: active_group = group_vi_i;
            efo_pkg::GSRC_LED: active_group = group_led_i;
            efo_pkg::GSRC_VO: active_group = group_vo_i;
            default: active_group = ctrl[efo_pkg::CTRL_GROUP_BIT];
        endcase
    end
    assign force_flag = ctrl[efo_pkg::CTRL_FORCE_BIT];

    always_comb
    begin
        for (int i = 0; i < NUM_STAGES; i++)
        begin
            // Inputs are already fundamental magnitudes from the filter
            case (efo_pkg::efo_input_e'(input_sel[i]))
                efo_pkg::SRC_A: meas[i] = clamp(residual_input_a_i, efo_pkg::RES_LIMIT);
                efo_pkg::SRC_B: meas[i] = clamp(residual_input_b_i, efo_pkg::RES_LIMIT);
                efo_pkg::SRC_CALC: meas[i] = clamp(summed_phase_residual_i,
                    efo_pkg::PHASE_LIMIT);
                efo_pkg::SRC_A_PEAK: meas[i] = peak_input_a_i;
                efo_pkg::SRC_B_PEAK: meas[i] = peak_input_b_i;
                default: meas[i] = residual_input_a_i;
            endcase
            if (input_sel[i] == efo_pkg::SRC_A_PEAK || input_sel[i] == efo_pkg::SRC_B_PEAK)
            begin
                over[i] = peak_hold[i];
                step[i] = efo_pkg::PEAK_STEP_MS;
            end
            else
            begin
                over[i] = meas[i] > pickup[i][active_group];
                // Inverse only on stage zero
                step[i] = (i == 0 && inverse_en[i]) ?
                    inv_step(meas[i], pickup[i][active_group]) : efo_pkg::TICK_MS[15:0];
            end
            start_d[i] = force_flag ? ctrl[efo_pkg::CTRL_FSTART_LSB + i] : over[i];
            trip_d[i] = force_flag ? ctrl[efo_pkg::CTRL_FTRIP_LSB + i]
                : (acc[i] > delay[i][active_group]);
        end
    end

    // A peak in the tick cycle carries into the next window instead of being lost
    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < NUM_STAGES; i++)
        begin
            peak_hold[i] <= !rst_i && ((peak_hold[i] && !ms_tick)
                || meas[i] > pickup[i][active_group]);
        end
    end

    // Delay accumulation with intermittent hold
    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < NUM_STAGES; i++)
        begin
            if (rst_i)
            begin
                acc[i] <= 16'h0;
                idle[i] <= 16'h0;
            end
            else if (ms_tick)
            begin
                if (over[i])
                begin
                    acc[i] <= sat_add(acc[i], step[i]);
                    idle[i] <= 16'h0;
                end
                else if (acc[i] != 16'h0)
                begin
                    if (sat_add(idle[i], 16'h0001) >= intermit[i])
                    begin
                        acc[i] <= 16'h0;
                        idle[i] <= 16'h0;
                    end
                    else
                        idle[i] <= idle[i] + 16'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        start_q <= rst_i ? '0 : start_d;
        trip_q <= rst_i ? '0 : trip_d;
    end

    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < NUM_STAGES; i++)
        begin
            if (rst_i || cnt_clear[i])
            begin
                start_event_count[i] <= 16'h0;
                trip_event_count[i] <= 16'h0;
            end
            else
            begin
                if (start_d[i] && !start_q[i])
                    start_event_count[i] <= start_event_count[i] + 16'h1;
                if (trip_d[i] && !trip_q[i])
                    trip_event_count[i] <= trip_event_count[i] + 16'h1;
            end
        end
    end

    assign events = {8'(trip_d & ~trip_q) << 4} | 8'(start_d & ~start_q);

    // AHB-Lite: writes land in the data phase, reads are registered
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h0;
            hrdata_o <= 32'h0;
        end
        else if (hready_i)
        begin
            wr_pend <= hsel_i && htrans_i[1] && hwrite_i;
            wr_addr <= haddr_i[7:0];
            if (hsel_i && htrans_i[1] && !hwrite_i)
                hrdata_o <= read_mux(haddr_i[7:0]);
        end
    end

    function automatic logic [31:0] read_mux(input logic [7:0] a);
        logic [1:0] s;
        logic [31:0] prim;
        s = a[6:5];
        prim = 32'(pickup[s][active_group]) * 32'(ct_rating[s]);
        read_mux = 32'h0;
        if (a[7])
        begin
            case (a[4:2])
                efo_pkg::SREG_PICKUP_G0: read_mux = {16'h0, pickup[s][0]};
                efo_pkg::SREG_PICKUP_G1: read_mux = {16'h0, pickup[s][1]};
                efo_pkg::SREG_DELAY_G0: read_mux = {16'h0, delay[s][0]};
                efo_pkg::SREG_DELAY_G1: read_mux = {16'h0, delay[s][1]};
                efo_pkg::SREG_CFG: read_mux = {intermit[s], 12'h0, inverse_en[s], input_sel[s]};
                efo_pkg::SREG_COUNTS: read_mux = {trip_event_count[s], start_event_count[s]};
                efo_pkg::SREG_PRIMARY: read_mux = {8'h0, prim[31:8]};
                default: read_mux = {16'h0, ct_rating[s]};
            endcase
        end
        else
        begin
            case (a)
                efo_pkg::REG_CTRL: read_mux = ctrl;
                efo_pkg::REG_IRQ_STATUS: read_mux = {24'h0, irq_status};
                efo_pkg::REG_IRQ_MASK: read_mux = {24'h0, irq_mask};
                efo_pkg::REG_STATE: read_mux = {22'h0, force_flag, active_group,
                    trip_q, start_q};
                default: read_mux = 32'h0;
            endcase
        end
    endfunction

    always_ff @(posedge clk_i)
    begin
        for (int i = 0; i < NUM_STAGES; i++)
        begin
            if (rst_i)
            begin
                pickup[i][0] <= efo_pkg::PICKUP_RESET;
                pickup[i][1] <= efo_pkg::PICKUP_RESET;
                delay[i][0] <= efo_pkg::DELAY_RESET;
                delay[i][1] <= efo_pkg::DELAY_RESET;
                input_sel[i] <= 3'h0;
                inverse_en[i] <= 1'b0;
                intermit[i] <= 16'h0;
                ct_rating[i] <= efo_pkg::CT_RESET;
            end
            else if (wr_en && wr_addr[7] && wr_addr[6:5] == 2'(i))
            begin
                case (wr_addr[4:2])
                    efo_pkg::SREG_PICKUP_G0: pickup[i][0] <= hwdata_i[15:0];
                    efo_pkg::SREG_PICKUP_G1: pickup[i][1] <= hwdata_i[15:0];
                    efo_pkg::SREG_DELAY_G0: delay[i][0] <= hwdata_i[15:0];
                    efo_pkg::SREG_DELAY_G1: delay[i][1] <= hwdata_i[15:0];
                    efo_pkg::SREG_CFG:
                    begin
                        input_sel[i] <= hwdata_i[2:0];
                        inverse_en[i] <= (i == 0) && hwdata_i[3];
                        intermit[i] <= hwdata_i[31:16];
                    end
                    efo_pkg::SREG_CT_RATING: ct_rating[i] <= hwdata_i[15:0];
                    default: ;
                endcase
            end
        end
    end

    // Force flag drops after its timeout
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ctrl <= 32'h0;
            force_cnt <= 32'h0;
        end
        else if (wr_en && wr_addr == efo_pkg::REG_CTRL)
        begin
            ctrl <= {16'h0, hwdata_i[15:8], 3'h0, hwdata_i[4:0]};
            force_cnt <= 32'h0;
        end
        else if (force_flag && ms_tick)
        begin
            if (force_cnt == FORCE_TIMEOUT_MS - 1)
            begin
                ctrl[efo_pkg::CTRL_FORCE_BIT] <= 1'b0;
                force_cnt <= 32'h0;
            end
            else
                force_cnt <= force_cnt + 32'h1;
        end
    end

    // Set wins over the write-one clear
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_status <= 8'h0;
            irq_mask <= 8'h0;
            cnt_clear <= '0;
        end
        else
        begin
            if (wr_en && wr_addr == efo_pkg::REG_IRQ_STATUS)
                irq_status <= (irq_status & ~hwdata_i[7:0]) | events;
            else
                irq_status <= irq_status | events;
            if (wr_en && wr_addr == efo_pkg::REG_IRQ_MASK)
                irq_mask <= hwdata_i[7:0];
            cnt_clear <= (wr_en && wr_addr == efo_pkg::REG_CNT_CLEAR) ?
                hwdata_i[NUM_STAGES-1:0] : '0;
        end
    end

    a_start_level: assert property (@(posedge clk_i) disable iff (rst_i)
        (!force_flag && input_sel[0] == 3'h0 && meas[0] > pickup[0][active_group])
        |=> start_o[0]) else $error("start not raised above pick-up");
    a_trip_delay: assert property (@(posedge clk_i) disable iff (rst_i)
        (!force_o && !$past(force_o) && trip_o[0])
        |-> $past(acc[0]) > $past(delay[0][active_group]))
        else $error("trip before delay elapsed");
    a_peak_step: assert property (@(posedge clk_i) disable iff (rst_i)
        (ms_tick && peak_hold[0] && input_sel[0] == 3'h3 && acc[0] < 16'hff00)
        |=> acc[0] == $past(acc[0]) + 16'h0014) else $error("peak step not 20 ms");
    a_intermit_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        (ms_tick && !over[0] && idle[0] + 16'h1 < intermit[0])
        |=> acc[0] == $past(acc[0])) else $error("delay count lost early");
    a_intermit_clear: assert property (@(posedge clk_i) disable iff (rst_i)
        (ms_tick && !over[0] && acc[0] != 16'h0 && idle[0] + 16'h1 >= intermit[0]
        && idle[0] != 16'hffff) |=> acc[0] == 16'h0) else $error("delay count not cleared");
    a_definite_only: assert property (@(posedge clk_i) disable iff (rst_i)
        (ms_tick && over[1] && input_sel[1] < 3'h3 && acc[1] != 16'hffff)
        |=> acc[1] == $past(acc[1]) + 16'h1) else $error("stage one not definite time");
    a_force_expire: assert property (@(posedge clk_i) disable iff (rst_i)
        (force_flag && ms_tick && force_cnt == FORCE_TIMEOUT_MS - 1 && !wr_en)
        |=> !force_o) else $error("force flag did not time out");
    a_start_count: assert property (@(posedge clk_i) disable iff (rst_i)
        (start_d[0] && !start_q[0] && !cnt_clear[0])
        |=> start_event_count[0] == $past(start_event_count[0]) + 16'h1)
        else $error("start counter missed");
    a_group_manual: assert property (@(posedge clk_i) disable iff (rst_i)
        ctrl[4:2] == 3'h0 |-> active_group_o == ctrl[1]) else $error("manual group ignored");
    a_irq_level: assert property (@(posedge clk_i) disable iff (rst_i)
        $rose(|events) |=> ##[0:1] (irq_status != 8'h0)) else $error("event not latched");
endmodule

// ===== verif/efo_field_model.sv
`timescale 1ns/1ps
module efo_field_model (
    input wire logic clk_i,
    input wire logic [15:0] level_i,
    input wire logic [1:0] sel_i,
    input wire logic peak_i,
    input wire logic [3:0] trip_i,
    output logic [15:0] res_a_o = 16'h0010,
    output logic [15:0] res_b_o = 16'h0010,
    output logic [15:0] calc_o = 16'h0010,
    output logic [15:0] peak_o = 16'h0010,
    output int relay_ops_o = 0
);
    // Idle inputs carry a small standing residual, never a clean zero
    localparam logic [15:0] BG = 16'h0010;
    logic [3:0] trip_q = 4'h0;
    always @(posedge clk_i)
    begin
        res_a_o <= sel_i == 2'd0 ? level_i : BG;
        res_b_o <= sel_i == 2'd1 ? level_i : BG;
        calc_o <= sel_i == 2'd2 ? level_i : BG;
        // Spike lasts one cycle, inside a single ms window
        peak_o <= peak_i ? level_i : BG;
        trip_q <= trip_i;
        relay_ops_o <= relay_ops_o + int'($countones(trip_i & ~trip_q));
    end
endmodule

// ===== verif/tb_earth_fault_overcurrent_stage.sv
`timescale 1ns/1ps
module tb_earth_fault_overcurrent_stage;
    localparam int T = 10;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'b00;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic hrdy;
    logic [31:0] hrdata;
    logic [15:0] level = 16'h0010;
    logic [1:0] sel = 2'd0;
    logic peak = 1'b0;
    logic [3:0] gsrc = 4'h0;
    logic [15:0] ra, rb, rc, pk;
    logic [3:0] start, trip;
    logic agrp, force_flag, irq;
    logic [31:0] rd;
    logic got;
    int relay_ops, base, n, k, j;
    int err_total = 0;
    int compares = 0;
    int cycles = 0;
    int seed = 63;
    efo_field_model i_field (.clk_i(clk_i), .level_i(level), .sel_i(sel), .peak_i(peak),
        .trip_i(trip), .res_a_o(ra), .res_b_o(rb), .calc_o(rc), .peak_o(pk),
        .relay_ops_o(relay_ops));
    efo_stage_top #(.MS_TICK_CYCLES(T), .FORCE_TIMEOUT_MS(3)) i_dut (.clk_i(clk_i),
        .rst_i(rst_i), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
        .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hrdy), .hreadyout_o(hrdy), .hresp_o(),
        .hrdata_o(hrdata), .residual_input_a_i(ra), .residual_input_b_i(rb),
        .summed_phase_residual_i(rc), .peak_input_a_i(pk), .peak_input_b_i(pk),
        .group_di_i(gsrc[0]), .group_vi_i(gsrc[1]), .group_led_i(gsrc[2]),
        .group_vo_i(gsrc[3]), .start_o(start), .trip_o(trip), .active_group_o(agrp),
        .force_o(force_flag), .irq_o(irq));
    initial
    begin
        forever #12.5 clk_i = ~clk_i;
    end
    task automatic close_out();
        $display("Counts: %0d compares, %0d mismatches", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            $display("ERROR %0t timeout", $time);
            close_out();
        end
    end
    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string w);
        compares++;
        if (g !== e)
        begin
            err_total++;
            $display("ERROR %0t %s got %h exp %h", $time, w, g, e);
        end
    endtask
    // Single AHB-Lite word transfer; address phase always follows one idle slot
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        hwrite <= wr;
        htrans <= 2'b10;
        @(posedge clk_i);
        while (hrdy !== 1'b1) @(posedge clk_i);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= d;
        @(posedge clk_i);
        while (hrdy !== 1'b1) @(posedge clk_i);
        rd = hrdata;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string w);
        bus(1'b0, a, 32'h0);
        chk(rd, e, w);
    endtask
    function automatic logic [7:0] sa(input int s, input logic [2:0] r);
        return 8'h80 + 8'(s * 32) + {3'h0, r, 2'h0};
    endfunction
    // Reference comparison: clamped measurement strictly above pick-up
    function automatic logic over(input int m, input int p, input int lim);
        return (m > lim ? lim : m) > p;
    endfunction
    task automatic setin(input logic [1:0] s, input logic [15:0] l);
        @(posedge clk_i);
        sel <= s;
        level <= l;
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge clk_i);
    endtask
    task automatic wt(input int s);
        n = 0;
        while (trip[s] !== 1'b1 && n < 400)
        begin
            @(posedge clk_i);
            n++;
        end
    endtask
    initial
    begin
        cyc(5);
        rst_i <= 1'b0;
        for (k = 0; k < 4; k++)
        begin
            rchk(sa(k, efo_pkg::SREG_PICKUP_G1), 32'(efo_pkg::PICKUP_RESET), "pickup");
            rchk(sa(k, efo_pkg::SREG_DELAY_G0), 32'(efo_pkg::DELAY_RESET), "delay");
            rchk(sa(k, efo_pkg::SREG_CT_RATING), 32'h1, "ct");
            rchk(sa(k, efo_pkg::SREG_COUNTS), 32'h0, "counts");
            bus(1'b1, sa(k, efo_pkg::SREG_CFG), 32'(k % 3));
        end
        bus(1'b1, 8'h40, 32'hffff_ffff);
        rchk(8'h40, 32'h0, "unmapped");
        $display("Test reset done");
        for (k = 0; k < 3; k++)
        begin
            n = 16'h0200 + ($random(seed) & 32'h3ff);
            setin(2'(k), 16'(n));
            cyc(4);
            chk(32'({k == 0, k == 2, k == 1, k == 0} & {4{over(n, 256, 2560)}}),
                32'(start), "source start");
        end
        setin(2'd0, 16'h0100);
        cyc(4);
        chk(32'(start), 32'h0, "equal level");
        $display("Test sources done");
        bus(1'b1, efo_pkg::REG_IRQ_MASK, 32'h40);
        bus(1'b1, sa(2, efo_pkg::SREG_DELAY_G0), 32'h2);
        setin(2'd2, 16'h0200);
        cyc(4);
        chk(32'(irq), 32'h0, "masked start");
        wt(2);
        chk(32'(n + 4 >= 2 * T && n + 4 <= 3 * T + 5), 32'h1, "trip delay");
        chk(32'(irq), 32'h1, "irq on trip");
        rchk(efo_pkg::REG_IRQ_STATUS, 32'h4f, "status");
        bus(1'b1, efo_pkg::REG_IRQ_STATUS, 32'hff);
        cyc(1);
        chk(32'(irq), 32'h0, "irq cleared");
        setin(2'd0, 16'h0010);
        cyc(T + 6);
        chk(32'(trip[2]), 32'h0, "trip drops");
        $display("Test trip done");
        bus(1'b1, efo_pkg::REG_CNT_CLEAR, 32'h8);
        bus(1'b1, sa(3, efo_pkg::SREG_DELAY_G0), 32'h3);
        for (j = 0; j < 2; j++)
        begin
            bus(1'b1, sa(3, efo_pkg::SREG_CFG), j ? 32'h0 : 32'h0005_0000);
            base = relay_ops;
            for (k = 0; k < 3; k++)
            begin
                setin(2'd0, 16'h0200);
                cyc(25);
                setin(2'd0, 16'h0010);
                cyc(15);
            end
            chk(32'(relay_ops - base), j ? 32'h0 : 32'h1, "intermittent");
            cyc(8 * T);
        end
        rchk(sa(3, efo_pkg::SREG_COUNTS), {16'd1, 16'd6}, "counters");
        bus(1'b1, efo_pkg::REG_CNT_CLEAR, 32'h8);
        rchk(sa(3, efo_pkg::SREG_COUNTS), 32'h0, "counter clear");
        $display("Test intermittent done");
        bus(1'b1, sa(0, efo_pkg::SREG_CFG), 32'h0064_0003);
        base = relay_ops;
        for (k = 0; k < 6; k++)
        begin
            if (k == 3) bus(1'b1, sa(0, efo_pkg::SREG_CFG), 32'h0064_0004);
            @(posedge clk_i);
            sel <= 2'd3;
            level <= 16'h0200;
            peak <= 1'b1;
            @(posedge clk_i);
            peak <= 1'b0;
            got = 1'b0;
            repeat (4) @(posedge clk_i) got |= start[0];
            chk(32'(got), 32'h1, "peak start");
            cyc(25);
            if (k == 4)
                chk(32'(relay_ops - base), 32'h0, "five peaks");
        end
        cyc(2 * T);
        chk(32'(relay_ops - base), 32'h1, "six peaks");
        setin(2'd0, 16'h0010);
        bus(1'b1, sa(0, efo_pkg::SREG_CFG), 32'h8);
        cyc(2 * T);
        bus(1'b1, sa(0, efo_pkg::SREG_PICKUP_G0), 32'h80);
        bus(1'b1, sa(0, efo_pkg::SREG_DELAY_G0), 32'h20);
        setin(2'd0, 16'h0900);
        wt(0);
        chk(32'(n <= 3 * T + 5), 32'h1, "inverse trip");
        bus(1'b1, sa(1, efo_pkg::SREG_CFG), 32'h9);
        rchk(sa(1, efo_pkg::SREG_CFG), 32'h1, "no inverse");
        $display("Test peak and inverse done");
        bus(1'b1, sa(3, efo_pkg::SREG_PICKUP_G0), 32'h0a00);
        bus(1'b1, sa(2, efo_pkg::SREG_PICKUP_G0), 32'h3100);
        setin(2'd0, 16'hffff);
        cyc(4);
        chk(32'(start[3]), 32'(over(65535, 2560, 2560)), "res clamp");
        setin(2'd2, 16'hffff);
        cyc(4);
        chk(32'(start[2]), 32'(over(65535, 12544, 12800)), "phase clamp");
        bus(1'b1, sa(1, efo_pkg::SREG_PICKUP_G1), 32'h800);
        setin(2'd1, 16'h0400);
        for (k = 0; k < 2; k++)
        begin
            bus(1'b1, efo_pkg::REG_CTRL, 32'(k << 1));
            cyc(3);
            chk(32'({agrp, start[1]}), k ? 32'h2 : 32'h1, "manual group");
        end
        for (k = 1; k < 5; k++)
        begin
            bus(1'b1, efo_pkg::REG_CTRL, 32'(k << 2));
            for (j = 0; j < 2; j++)
            begin
                @(posedge clk_i);
                gsrc <= j ? ~(4'h1 << (k - 1)) : 4'h1 << (k - 1);
                cyc(3);
                chk(32'(agrp), 32'(1 - j), "group source");
            end
        end
        $display("Test clamp and groups done");
        setin(2'd0, 16'h0010);
        bus(1'b1, efo_pkg::REG_CTRL, 32'h5f01);
        cyc(2);
        chk(32'({force_flag, start, trip}), 32'h1f5, "forced");
        rchk(efo_pkg::REG_STATE, 32'h25f, "state");
        cyc(4 * T);
        chk(32'(force_flag), 32'h0, "force timeout");
        bus(1'b1, sa(2, efo_pkg::SREG_PICKUP_G0), 32'h180);
        bus(1'b1, sa(2, efo_pkg::SREG_CT_RATING), 32'd200);
        rchk(sa(2, efo_pkg::SREG_PRIMARY), 32'((384 * 200) >> 8), "primary");
        $display("Test force and primary done");
        close_out();
    end
endmodule
